// >>> hdl/rcsp_pkg.sv
package rcsp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_NS         = 500;
    localparam int unsigned TICK_CYC        = (CLK_HZ / 1_000_000) * TICK_NS
                                              / 1_000;
    localparam int unsigned UNIT_TICKS      = 20;
    localparam int unsigned TIMER_SPAN      = 65_536;
    localparam int unsigned FRAME_TICKS_DEF = 40_000;
    localparam logic [15:0] PRELOAD_DEF     = 16'(TIMER_SPAN - FRAME_TICKS_DEF);
    localparam logic [7:0]  PULSE_RST       = 8'h00;
    localparam int unsigned NUM_CH          = 8;

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RCSP_CMD_START  = 2'b00,
        RCSP_CMD_UPDATE = 2'b01,
        RCSP_CMD_HIGH   = 2'b10,
        RCSP_CMD_LOW    = 2'b11
    } rcsp_cmd_e;

    typedef struct packed {
        rcsp_cmd_e   cmd;
        logic [2:0]  chan;
        logic [7:0]  pulse;
        logic        use_preload;
        logic [15:0] preload;
    } rcsp_req_s;

    typedef enum logic [1:0] {
        RCSP_ST_IDLE  = 2'b00,
        RCSP_ST_PULSE = 2'b01,
        RCSP_ST_WAIT  = 2'b10
    } rcsp_state_e;

endpackage : rcsp_pkg

// >>> hdl/rcsp_top.sv
`timescale 1ns/1ns
// Function
// - Started channel drives high for value times 0.01 ms, once each frame.
// - Pulsing persists until a high or low command; a new start keeps it running.
// - High or low command ends pulsing at once, pin holds that level.
// - New start replaces the stored pulse width.
// - Start enables pulsing and restarts the shared frame timer.
// - Update changes width only, frame timer untouched.
// - Pulse output is suspended while a serial transfer is busy.
// - Frame timer loads a 16-bit preload, counts 0.5 us steps to wrap.
// - Default frame is 40000 steps, 20 ms.
// - Only channels 0 to 7, chosen by a 3-bit number.
// - Timing holds only at supported clock rates.
module rcsp_top
    import rcsp_pkg::*;
#(
    parameter int unsigned CH = NUM_CH
) (
    input  wire logic            clk_sys_i,
    input  wire logic            nrst_i,
    input  wire logic            req_valid_i,
    input  rcsp_req_s            req_i,
    input  wire logic            serial_busy_i,
    output logic [CH-1:0]        pin_o,
    output logic [CH-1:0]        active_o,
    output logic                 frame_o
);

    initial begin
        if (CH != NUM_CH || TICK_CYC < 1) begin
            $error("rcsp_top: unsupported channel count or clock");
        end
    end

    // ------------------------------------------------------------
    // Tick prescaler and frame timer
    // ------------------------------------------------------------
    logic [7:0]  pre_reg;
    logic        tick;
    logic [15:0] timer_reg;
    logic [15:0] preload_reg;
    logic        frame_start;
    logic        restart;

    assign tick = (pre_reg == 8'(TICK_CYC - 1));
    assign restart = req_valid_i && req_i.cmd == RCSP_CMD_START;
    assign frame_start = tick && (timer_reg == 16'hFFFF);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg <= 8'h00;
        end else if (restart || tick) begin
            pre_reg <= 8'h00;
        end else begin
            pre_reg <= pre_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            preload_reg <= PRELOAD_DEF;
        end else if (restart) begin
            preload_reg <= req_i.use_preload ? req_i.preload : PRELOAD_DEF;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_reg <= PRELOAD_DEF;
        end else if (restart) begin
            timer_reg <= req_i.use_preload ? req_i.preload : PRELOAD_DEF;
        end else if (frame_start) begin
            timer_reg <= preload_reg;
        end else if (tick) begin
            timer_reg <= timer_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_o <= 1'b0;
        end else begin
            frame_o <= frame_start;
        end
    end

    // ------------------------------------------------------------
    // Channel table
    // ------------------------------------------------------------
    logic [7:0]    width_reg [CH];
    logic [CH-1:0] level_reg;

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_ch
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    width_reg[g] <= PULSE_RST;
                    active_o[g]  <= 1'b0;
                    level_reg[g] <= 1'b0;
                end else if (req_valid_i && req_i.chan == 3'(g)) begin
                    case (req_i.cmd)
                        RCSP_CMD_START: begin
                            width_reg[g] <= req_i.pulse;
                            active_o[g]  <= 1'b1;
                        end
                        RCSP_CMD_UPDATE: begin
                            width_reg[g] <= req_i.pulse;
                        end
                        RCSP_CMD_HIGH: begin
                            active_o[g]  <= 1'b0;
                            level_reg[g] <= 1'b1;
                        end
                        RCSP_CMD_LOW: begin
                            active_o[g]  <= 1'b0;
                            level_reg[g] <= 1'b0;
                        end
                        default: begin
                            active_o[g] <= active_o[g];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    rcsp_state_e state_reg;
    logic [2:0]  cur_reg;
    logic [7:0]  units_reg;
    logic [4:0]  sub_reg;
    logic        busy_s1_reg;
    logic        busy_reg;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_s1_reg <= 1'b0;
            busy_reg    <= 1'b0;
        end else begin
            busy_s1_reg <= serial_busy_i;
            busy_reg    <= busy_s1_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= RCSP_ST_IDLE;
            cur_reg   <= 3'd0;
            units_reg <= 8'h00;
            sub_reg   <= 5'd0;
        end else begin
            case (state_reg)
                RCSP_ST_IDLE: begin
                    if (frame_start && !busy_reg) begin
                        cur_reg   <= 3'd0;
                        state_reg <= RCSP_ST_WAIT;
                    end
                end
                RCSP_ST_WAIT: begin
                    // Find next active channel in order
                    if (active_o[cur_reg] && width_reg[cur_reg] != 8'h00) begin
                        units_reg <= width_reg[cur_reg];
                        sub_reg   <= 5'd0;
                        state_reg <= RCSP_ST_PULSE;
                    end else if (cur_reg == 3'(CH - 1)) begin
                        state_reg <= RCSP_ST_IDLE;
                    end else begin
                        cur_reg <= cur_reg + 3'd1;
                    end
                end
                RCSP_ST_PULSE: begin
                    if (!active_o[cur_reg] || busy_reg) begin
                        state_reg <= RCSP_ST_IDLE;
                    end else if (tick) begin
                        if (sub_reg == 5'(UNIT_TICKS - 1)) begin
                            sub_reg <= 5'd0;
                            if (units_reg == 8'h01) begin
                                if (cur_reg == 3'(CH - 1)) begin
                                    state_reg <= RCSP_ST_IDLE;
                                end else begin
                                    cur_reg   <= cur_reg + 3'd1;
                                    state_reg <= RCSP_ST_WAIT;
                                end
                            end
                            units_reg <= units_reg - 8'h01;
                        end else begin
                            sub_reg <= sub_reg + 5'd1;
                        end
                    end
                end
                default: begin
                    state_reg <= RCSP_ST_IDLE;
                end
            endcase
            if (restart) begin
                state_reg <= RCSP_ST_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    generate
        for (g = 0; g < CH; g++) begin : g_pin
            always_ff @(posedge clk_sys_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pin_o[g] <= 1'b0;
                end else if (!active_o[g]) begin
                    pin_o[g] <= level_reg[g];
                end else begin
                    pin_o[g] <= state_reg == RCSP_ST_PULSE
                                && cur_reg == 3'(g)
                                && !busy_reg;
                end
            end
        end
    endgenerate

endmodule : rcsp_top

// >>> verif/rcsp_chk_sva.sv
`timescale 1ns/1ns
module rcsp_chk
    import rcsp_pkg::*;
#(
    parameter int unsigned CH = NUM_CH
) (
    input  wire logic          clk_sys_i,
    input  wire logic          nrst_i,
    input  wire logic          req_valid_i,
    input  rcsp_req_s          req_i,
    input  wire logic          serial_busy_i,
    input  wire logic [CH-1:0] pin_o,
    input  wire logic [CH-1:0] active_o,
    input  wire logic          frame_o
);
    // ------
    // Frame spacing helper
    // ------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    wire         st = req_valid_i && req_i.cmd == RCSP_CMD_START;
    logic [31:0] gap_reg;
    logic        arm_reg;
    logic [15:0] pre_reg;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_reg <= '0;
            arm_reg <= 1'b0;
            pre_reg <= PRELOAD_DEF;
        end else begin
            gap_reg <= frame_o ? 32'h0000_0001 : gap_reg + 1;
            arm_reg <= !st && (frame_o || arm_reg);
            if (st)
                pre_reg <= req_i.use_preload ? req_i.preload : PRELOAD_DEF;
        end
    end
    property p_stop(rcsp_cmd_e k, logic lvl);
        int c;
        (req_valid_i && req_i.cmd == k, c = req_i.chan)
            |=> !active_o[c] ##1 pin_o[c] == lvl;
    endproperty
    property p_start;
        int c;
        (st && req_i.pulse != 0, c = req_i.chan) |=> active_o[c];
    endproperty
    a_high_stops: assert property (p_stop(RCSP_CMD_HIGH, 1'b1))
        else $error("pin not held high");
    a_low_stops: assert property (p_stop(RCSP_CMD_LOW, 1'b0))
        else $error("pin not held low");
    a_start_arms: assert property (p_start)
        else $error("start did not arm channel");
    a_update_keeps: assert property (req_valid_i &&
        req_i.cmd == RCSP_CMD_UPDATE |=> active_o == $past(active_o))
        else $error("update changed active set");
    a_frame_period: assert property (frame_o && arm_reg |->
        gap_reg == (TIMER_SPAN - pre_reg) * TICK_CYC)
        else $error("frame period wrong");
    a_busy_quiet: assert property (serial_busy_i [*5] |->
        (pin_o & active_o) == '0) else $error("pulse during busy");
    a_active_holds: assert property (|($past(active_o) & ~active_o) |->
        $past(req_valid_i) &&
        $past(req_i.cmd) inside {RCSP_CMD_HIGH, RCSP_CMD_LOW})
        else $error("pulsing ended without command");
    a_single_pulse: assert property ($onehot0(pin_o & active_o))
        else $error("overlapping pulses");
    c_frame: cover property (frame_o && arm_reg);
    c_busy: cover property (serial_busy_i && active_o != '0);
    c_high: cover property (req_valid_i && req_i.cmd == RCSP_CMD_HIGH);
endmodule : rcsp_chk
bind rcsp_top rcsp_chk #(.CH(CH)) rcsp_chk_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .serial_busy_i(serial_busy_i), .pin_o(pin_o),
    .active_o(active_o), .frame_o(frame_o));

// >>> verif/rcsp_servo_mdl.sv
`timescale 1ns/1ns
module rcsp_servo_mdl
    import rcsp_pkg::*;
(
    input  wire logic [7:0] pin_i,
    input  wire logic       clk_sys_i,
    output logic            seen_o,
    output logic [2:0]      ch_o,
    output logic [31:0]     width_o
);
    // ------
    // Servo side: times each high pulse, reports it on the fall
    // ------
    logic [31:0] cnt_reg [8];
    logic [7:0]  last_reg;
    always_ff @(posedge clk_sys_i) begin
        seen_o <= 1'b0;
        last_reg <= pin_i;
        for (int i = 0; i < 8; i++) begin
            cnt_reg[i] <= pin_i[i] ? cnt_reg[i] + 1 : 32'h0000_0000;
            if (last_reg[i] && !pin_i[i]) begin
                seen_o <= 1'b1;
                ch_o <= 3'(i);
                width_o <= cnt_reg[i];
            end
        end
    end
endmodule : rcsp_servo_mdl

// >>> verif/rcsp_top_tb_top.sv
`timescale 1ns/1ns
module rcsp_top_tb_top;
    import rcsp_pkg::*;
    // ------
    // Stimulus and scoreboard
    // ------
    localparam int W = UNIT_TICKS * TICK_CYC;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic        serial_busy_i = 1'b0;
    rcsp_req_s   req_i = '0;
    logic [7:0]  pin_o;
    logic [7:0]  active_o;
    logic        frame_o;
    logic        seen;
    logic [2:0]  sch;
    logic [31:0] sw;
    logic [31:0] rng = 32'h0000_7ae0;
    logic [34:0] e;
    logic [34:0] q[$];
    int          p[8];
    int          num_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    rcsp_top rcsp_top_i (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .serial_busy_i(serial_busy_i), .pin_o(pin_o),
        .active_o(active_o), .frame_o(frame_o));
    rcsp_servo_mdl rcsp_servo_mdl_i (.clk_sys_i(clk_sys_i), .pin_i(pin_o),
        .seen_o(seen), .ch_o(sch), .width_o(sw));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        compares++;
        if (s !== x) begin
            num_errors++;
            $display("[ERR] %s exp %0h seen %0h", n, x, s);
        end
    endtask : chk
    task automatic cmd(rcsp_cmd_e k, int c, int v);
        @(negedge clk_sys_i);
        req_valid_i = 1'b1;
        req_i = '{k, 3'(c), 8'(v), 1'b1, 16'hFFC0};
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
    endtask : cmd
    task automatic drain();
        for (int t = 0; t < 40000 && q.size() != 0; t++)
            @(negedge clk_sys_i);
        chk("drain", 32'(q.size()), 0);
    endtask : drain
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    always @(negedge clk_sys_i) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            tally_and_finish();
        end else if (seen === 1'b1 && q.size() != 0) begin
            e = q.pop_front();
            chk("chan", sch, e[34:32]);
            chk("width", (sw + 2 >= e[31:0] && sw <= e[31:0] + 3) ?
                e[31:0] : sw, e[31:0]);
        end
    end
    initial begin
        repeat (20) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        q.push_back({3'd0, 32'(75 * W)});
        cmd(RCSP_CMD_START, 0, 75);
        drain();
        q.push_back({3'd0, 32'(80 * W)});
        cmd(RCSP_CMD_UPDATE, 0, 80);
        drain();
        cmd(RCSP_CMD_LOW, 0, 0);
        $display("test update done");
        for (int i = 7; i >= 0; i--) begin
            p[i] = xs() % 4 + 1;
            cmd(RCSP_CMD_START, i, p[i]);
        end
        repeat (2) for (int i = 0; i < 8; i++)
            q.push_back({3'(i), 32'(p[i] * W)});
        drain();
        for (int i = 0; i < 8; i++)
            cmd(i == 5 ? RCSP_CMD_HIGH : RCSP_CMD_LOW, i, 0);
        repeat (4) @(negedge clk_sys_i);
        chk("pins", pin_o, 8'h20);
        $display("test multi done");
        serial_busy_i = 1'b1;
        cmd(RCSP_CMD_START, 1, 4);
        repeat (3000) @(negedge clk_sys_i);
        chk("active", active_o, 8'h02);
        serial_busy_i = 1'b0;
        q.push_back({3'd1, 32'(4 * W)});
        drain();
        $display("test busy done");
        tally_and_finish();
    end
endmodule : rcsp_top_tb_top
